/* File: src/brsc_pkg.sv */
// package of the board reset source controller: register map, field
// positions, reset values and timing constants.
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package brsc_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned POR_HOLD_MS   = 140;
  localparam int unsigned POR_HOLD_CYC  = POR_HOLD_MS * CLK_PER_MS;
  localparam int unsigned SW_PULSE_MS   = 200;
  localparam int unsigned SW_PULSE_CYC  = SW_PULSE_MS * CLK_PER_MS;
  localparam int unsigned FP_HOLD_S     = 3;
  localparam int unsigned FP_HOLD_CYC   = FP_HOLD_S * CLK_HZ;
  localparam int unsigned CHIP_RST_NS   = 1000;
  localparam int unsigned CHIP_RST_CYC  = (CHIP_RST_NS * 100 + 999) / 1000;
  localparam int unsigned SOFT_RST_NS   = 1000;
  localparam int unsigned SOFT_RST_CYC  = (SOFT_RST_NS * 100 + 999) / 1000;
  localparam int unsigned CNT_W         = 32;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SW_HARD_OFS   = 8'h04;
  localparam logic [7:0] PROC_INIT_OFS = 8'h08;
  localparam logic [7:0] CHIP_RST_OFS  = 8'h0c;
  localparam logic [7:0] SOURCE_OFS    = 8'h10;

  // control register fields
  localparam int unsigned WDA_EN_BIT   = 0;
  localparam int unsigned WDB_EN_BIT   = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h0;

  // trigger bit of the write-to-act registers
  localparam int unsigned TRIG_BIT     = 0;

  // reset source register: one bit per source
  localparam int unsigned NSRC         = 7;
  localparam int unsigned SRC_POWER    = 0;
  localparam int unsigned SRC_PANEL    = 1;
  localparam int unsigned SRC_BACKPL   = 2;
  localparam int unsigned SRC_WDOG     = 3;
  localparam int unsigned SRC_SWHARD   = 4;
  localparam int unsigned SRC_BRSEC    = 5;
  localparam int unsigned SRC_BRCHIP   = 6;
  localparam logic [6:0]  SOURCE_RST   = 7'h01;

  // number of asynchronous inputs passed through the synchroniser
  localparam int unsigned NSYNC        = 6;

endpackage

/* File: src/brsc_sync.sv */
// two-flop synchroniser, one lane per bit.
// assumes the inputs are asynchronous levels; nothing reads stage one.
`timescale 1ns/1ps
module brsc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : lane
      logic meta_reg;
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          meta_reg  <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_reg  <= async_i[g];
          sync_o[g] <= meta_reg;
        end
      end
    end
  endgenerate

endmodule

/* File: src/brsc_top.sv */
// board reset source controller: merges seven reset sources into a board
// hard reset and a processor-only soft reset, stretches them, and keeps a
// software-readable record of the source of the last hard reset.
// assumes a 100 MHz clock and an always-powered reset rst_i that this
// block's own hard reset outputs never feed back into.
//
// How it works
// - hard reset resets processor and all peripherals
// - soft reset resets processor only
// - seven separate reset sources accepted
// - power-up holds hard reset 140-560 ms
// - undervoltage holds reset until 140 ms after
// - panel switch acts after held over 3 s
// - panel reset lasts while switch stays pressed
// - bridge secondary reset becomes board hard reset
// - enabled watchdog expiry gives hard reset
// - legacy port write gives 200 ms hard reset
// - legacy port reset spares the bridge
// - processor init write gives soft reset
// - secondary bit resets buffers and board, not bridge
// - chip reset bit resets all but the bridge buffers, then self-clears
// - reset source register names the cause
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module brsc_top
  import brsc_pkg::*;
#(
  parameter int unsigned POR_CYC = brsc_pkg::POR_HOLD_CYC,
  parameter int unsigned SW_CYC  = brsc_pkg::SW_PULSE_CYC,
  parameter int unsigned FP_CYC  = brsc_pkg::FP_HOLD_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // avalon-mm register port
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // asynchronous reset sources
  input  wire logic        power_good_i,
  input  wire logic        panel_switch_n_i,
  input  wire logic        backplane_pushbutton_reset_n_i,
  input  wire logic        bridge_sec_reset_n_i,
  input  wire logic        wdog_a_expired_i,
  input  wire logic        wdog_b_expired_i,
  // reset outputs, active high
  output logic             cpu_reset_o,
  output logic             periph_reset_o,
  output logic             bridge_reset_o,
  output logic             bridge_buf_reset_o
);

  import brsc_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] syn;
  logic             pg_s;
  logic             panel_s;
  logic             backplane_pushbutton_reset_s;
  logic             sec_s;
  logic             wda_s;
  logic             wdb_s;

  // power good enters uninverted so a cleared stage reads as undervoltage
  assign raw = {wdog_b_expired_i, wdog_a_expired_i, ~bridge_sec_reset_n_i,
                ~backplane_pushbutton_reset_n_i, ~panel_switch_n_i,
                power_good_i};

  brsc_sync #(
    .W       (NSYNC)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (raw),
    .sync_o  (syn)
  );

  // undervoltage reads as asserted until the synchroniser has filled
  assign pg_s    = ~syn[0];
  assign panel_s = syn[1];
  assign backplane_pushbutton_reset_s  = syn[2];
  assign sec_s   = syn[3];
  assign wda_s   = syn[4];
  assign wdb_s   = syn[5];

  // ************************************************************
  // register port
  // ************************************************************
  logic             wait_reg;
  logic [31:0]      rdata_reg;
  logic [1:0]       ctrl_reg;
  logic             wr_go;
  logic             rd_go;
  logic             trig_wr;
  logic             sw_hard_wr;
  logic             proc_init_wr;
  logic             chip_wr;
  logic [NSRC-1:0]  source_reg;
  logic [CNT_W-1:0] sw_cnt_reg;
  logic [CNT_W-1:0] soft_cnt_reg;
  logic [CNT_W-1:0] chip_cnt_reg;
  logic             sw_on;
  logic             soft_on;
  logic             chip_on;

  // every access is answered in the cycle after it is first seen
  assign wr_go   = avs_write_i & ~wait_reg;
  assign rd_go   = avs_read_i & ~wait_reg;
  assign trig_wr = wr_go & avs_byteenable_i[0] & avs_writedata_i[TRIG_BIT];
  assign sw_hard_wr   = trig_wr & (avs_address_i == SW_HARD_OFS);
  assign proc_init_wr = trig_wr & (avs_address_i == PROC_INIT_OFS);
  assign chip_wr      = trig_wr & (avs_address_i == CHIP_RST_OFS);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wait_reg <= 1'b1;
    else if ((avs_read_i | avs_write_i) & wait_reg)
      wait_reg <= 1'b0;
    else
      wait_reg <= 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_reg <= CTRL_RST;
    else if (wr_go & avs_byteenable_i[0] & (avs_address_i == CTRL_OFS))
      ctrl_reg <= avs_writedata_i[1:0];
  end

  // read data are loaded at the edge that drops waitrequest
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_reg <= 32'h0;
    else if ((avs_read_i | avs_write_i) & wait_reg)
    begin
      case (avs_address_i)
        CTRL_OFS:      rdata_reg <= {30'h0, ctrl_reg};
        SW_HARD_OFS:   rdata_reg <= {31'h0, sw_on};
        PROC_INIT_OFS: rdata_reg <= {31'h0, soft_on};
        CHIP_RST_OFS:  rdata_reg <= {31'h0, chip_on};
        SOURCE_OFS:    rdata_reg <= {25'h0, source_reg};
        default:       rdata_reg <= 32'h0;
      endcase
    end
  end

  assign avs_waitrequest_o = wait_reg;
  assign avs_readdata_o    = rdata_reg;

  // ************************************************************
  // software triggered pulses
  // ************************************************************
  assign sw_on   = (sw_cnt_reg != '0);
  assign soft_on = (soft_cnt_reg != '0);
  assign chip_on = (chip_cnt_reg != '0);

  // a second write during the pulse restarts it from full length
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sw_cnt_reg <= '0;
    else if (sw_hard_wr)
      sw_cnt_reg <= CNT_W'(SW_CYC);
    else if (sw_on)
      sw_cnt_reg <= sw_cnt_reg - CNT_W'(1);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      soft_cnt_reg <= '0;
    else if (proc_init_wr)
      soft_cnt_reg <= CNT_W'(SOFT_RST_CYC);
    else if (soft_on)
      soft_cnt_reg <= soft_cnt_reg - CNT_W'(1);
  end

  // the chip reset bit reads one until the chip reset has run out
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      chip_cnt_reg <= '0;
    else if (chip_wr & ~chip_on)
      chip_cnt_reg <= CNT_W'(CHIP_RST_CYC);
    else if (chip_on)
      chip_cnt_reg <= chip_cnt_reg - CNT_W'(1);
  end

  // ************************************************************
  // power, undervoltage and watchdog stretch
  // ************************************************************
  logic [CNT_W-1:0] por_cnt_reg;
  logic             wd_hit;
  logic             por_on;

  assign wd_hit = (wda_s & ctrl_reg[WDA_EN_BIT]) |
                  (wdb_s & ctrl_reg[WDB_EN_BIT]);
  assign por_on = pg_s | (por_cnt_reg != '0);

  // the hold time is counted from the last cycle the cause was present
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      por_cnt_reg <= CNT_W'(POR_CYC);
    else if (pg_s | wd_hit)
      por_cnt_reg <= CNT_W'(POR_CYC);
    else if (por_cnt_reg != '0)
      por_cnt_reg <= por_cnt_reg - CNT_W'(1);
  end

  // ************************************************************
  // front panel switch
  // ************************************************************
  logic [CNT_W-1:0] fp_cnt_reg;
  logic             fp_on;

  // a bounce that releases the switch restarts the three second wait
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fp_cnt_reg <= '0;
    else if (~panel_s)
      fp_cnt_reg <= '0;
    else if (fp_cnt_reg != CNT_W'(FP_CYC))
      fp_cnt_reg <= fp_cnt_reg + CNT_W'(1);
  end

  assign fp_on = panel_s & (fp_cnt_reg == CNT_W'(FP_CYC));

  // ************************************************************
  // reset outputs and source record
  // ************************************************************
  logic            hard_on;
  logic            bridge_on;
  logic            hard_prev_reg;
  logic [NSRC-1:0] src_now;
  logic            cpu_reset_reg;
  logic            periph_reset_reg;
  logic            bridge_reset_reg;
  logic            bridge_buf_reset_reg;

  // secondary reset covers backplane reset and remote writes alike
  assign hard_on   = por_on | fp_on | backplane_pushbutton_reset_s | sec_s |
                     sw_on | chip_on;
  assign bridge_on = por_on | fp_on | backplane_pushbutton_reset_s | chip_on;

  always_comb
  begin
    src_now             = '0;
    src_now[SRC_POWER]  = pg_s | (por_on & ~wd_hit);
    src_now[SRC_PANEL]  = fp_on;
    src_now[SRC_BACKPL] = backplane_pushbutton_reset_s;
    src_now[SRC_WDOG]   = wd_hit;
    src_now[SRC_SWHARD] = sw_on;
    src_now[SRC_BRSEC]  = sec_s & ~backplane_pushbutton_reset_s;
    src_now[SRC_BRCHIP] = chip_on;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      hard_prev_reg <= 1'b1;
    else
      hard_prev_reg <= hard_on;
  end

  // latched only as a hard reset begins, so later overlaps do not blur it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      source_reg <= SOURCE_RST;
    else if (hard_on & ~hard_prev_reg)
      source_reg <= src_now;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cpu_reset_reg        <= 1'b1;
      periph_reset_reg     <= 1'b1;
      bridge_reset_reg     <= 1'b1;
      bridge_buf_reset_reg <= 1'b0;
    end
    else
    begin
      cpu_reset_reg        <= hard_on | soft_on;
      periph_reset_reg     <= hard_on;
      bridge_reset_reg     <= bridge_on;
      bridge_buf_reset_reg <= sec_s & ~backplane_pushbutton_reset_s;
    end
  end

  assign cpu_reset_o        = cpu_reset_reg;
  assign periph_reset_o     = periph_reset_reg;
  assign bridge_reset_o     = bridge_reset_reg;
  assign bridge_buf_reset_o = bridge_buf_reset_reg;

endmodule

/* File: testbench/brsc_assertions.sv */
// checker for the board reset source controller top level.
// assumes it is bound to brsc_top and sees that module's ports only.
`timescale 1ns/1ps
module brsc_assertions
  import brsc_pkg::*;
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register port
  input wire logic [7:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  // sources and resets
  input wire logic        power_good_i,
  input wire logic        backplane_pushbutton_reset_n_i,
  input wire logic        cpu_reset_o,
  input wire logic        periph_reset_o,
  input wire logic        bridge_reset_o,
  input wire logic        bridge_buf_reset_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // a write takes effect at the edge that sees waitrequest low
  wire go = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
            avs_writedata_i[0];
  // ********
  // properties
  // ********
  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("access not answered in one cycle");
  AST_PERIPH_CPU: assert property (periph_reset_o |-> cpu_reset_o)
    else $error("hard reset without processor reset");
  AST_BUF_SPARE: assert property (bridge_buf_reset_o |->
    !bridge_reset_o && periph_reset_o)
    else $error("buffer reset touched bridge state");
  AST_BKPL: assert property (!backplane_pushbutton_reset_n_i[*4]
    |-> periph_reset_o)
    else $error("backplane reset not passed on");
  AST_POWER: assert property (!power_good_i[*4] |-> periph_reset_o)
    else $error("undervoltage without hard reset");
  AST_SWHARD: assert property (go && avs_address_i == SW_HARD_OFS
    |-> ##2 periph_reset_o)
    else $error("legacy port write gave no hard reset");
  AST_INIT: assert property (go && avs_address_i == PROC_INIT_OFS
    |-> ##[1:3] cpu_reset_o)
    else $error("processor init gave no soft reset");
  AST_CHIP: assert property (go && avs_address_i == CHIP_RST_OFS
    |-> ##[1:3] (bridge_reset_o && periph_reset_o))
    else $error("chip reset missed the bridge");
  COV_SW: cover property (go && avs_address_i == SW_HARD_OFS);
  COV_CHIP: cover property (go && avs_address_i == CHIP_RST_OFS);
  COV_BUF: cover property (bridge_buf_reset_o);
endmodule

bind brsc_top brsc_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .power_good_i(power_good_i),
  .backplane_pushbutton_reset_n_i(backplane_pushbutton_reset_n_i),
  .cpu_reset_o(cpu_reset_o), .periph_reset_o(periph_reset_o),
  .bridge_reset_o(bridge_reset_o), .bridge_buf_reset_o(bridge_buf_reset_o));

/* File: testbench/brsc_far.sv */
// far side: supply monitor, panel switch, backplane, bridge, watchdogs.
// assumes the bench sets the request levels just after a clock edge.
`timescale 1ns/1ps
module brsc_far (
  // clock
  input  wire logic clk_i,
  // requests from the bench
  input  wire logic pg_i,
  input  wire logic press_i,
  input  wire logic bp_i,
  input  wire logic host_i,
  input  wire logic wda_i,
  input  wire logic wdb_i,
  // pins of the block
  output logic      power_good_o,
  output logic      panel_switch_n_o,
  output logic      bp_reset_n_o,
  output logic      sec_reset_n_o = 1'b1,
  output logic      wda_o,
  output logic      wdb_o
);
  assign power_good_o     = pg_i;
  assign panel_switch_n_o = !press_i;
  assign bp_reset_n_o     = !bp_i;
  assign wda_o            = wda_i;
  assign wdb_o            = wdb_i;
  // bridge answers a backplane reset or a remote host write a clock
  // later; only the remote host sets the bit, never the local cpu
  always @(posedge clk_i)
    sec_reset_n_o <= !(bp_i || host_i);
endmodule

/* File: testbench/tb.sv */
// self-checking bench of the board reset source controller.
// assumes short stretch counts given to brsc_top by parameter.
`timescale 1ns/1ps
module tb;
  import brsc_pkg::*;
  localparam int POR = 20;
  localparam int SW  = 30;
  localparam int FP  = 40;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  adr   = 8'h00;
  logic        re    = 1'b0;
  logic        we    = 1'b0;
  logic [31:0] wd    = 32'h0;
  logic        pg    = 1'b1;
  logic        press = 1'b0;
  logic        bp    = 1'b0;
  logic        host  = 1'b0;
  logic        wda   = 1'b0;
  logic        wdb   = 1'b0;
  logic [31:0] rdat, d;
  logic        wq, cpu, per, brg, bfr, pgw, swn, bpn, secn, wa, wb;
  int          miscompares = 0;
  int          tests_run = 0;
  int          n;
  brsc_top #(.POR_CYC(POR), .SW_CYC(SW), .FP_CYC(FP)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(re), .avs_write_i(we), .avs_byteenable_i(4'hf),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .power_good_i(pgw), .panel_switch_n_i(swn),
    .backplane_pushbutton_reset_n_i(bpn), .bridge_sec_reset_n_i(secn),
    .wdog_a_expired_i(wa), .wdog_b_expired_i(wb), .cpu_reset_o(cpu),
    .periph_reset_o(per), .bridge_reset_o(brg), .bridge_buf_reset_o(bfr));
  brsc_far far (.clk_i(clk_i), .pg_i(pg), .press_i(press), .bp_i(bp),
    .host_i(host), .wda_i(wda), .wdb_i(wdb), .power_good_o(pgw),
    .panel_switch_n_o(swn), .bp_reset_n_o(bpn), .sec_reset_n_o(secn),
    .wda_o(wa), .wdb_o(wb));
  initial
    forever #5 clk_i = ~clk_i;
  // ********
  // helpers
  // ********
  task test_done;
    if (miscompares == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task quit;
    miscompares++;
    $display("[ERR] %0t wait ran out", $time);
    test_done;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // one access; held until the edge that sees waitrequest low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk_i);
    adr <= a;
    wd <= v;
    we <= w;
    re <= !w;
    k = 0;
    do @(posedge clk_i); while (wq !== 1'b0 && ++k < 50);
    d = rdat;
    we <= 1'b0;
    re <= 1'b0;
    if (k >= 50)
      quit;
  endtask
  function logic sg(input int s);
    return s == 0 ? per : s == 1 ? cpu : brg;
  endfunction
  // counts edges until a reset output shows v; lim bounds the wait
  task wt(input int s, input logic v, input int lim, input bit must);
    for (n = 0; sg(s) !== v && n < lim; n++)
      @(posedge clk_i);
    if (must && n >= lim)
      quit;
  endtask
  task src(input logic [31:0] e);
    bus(1'b0, SOURCE_OFS, 32'h0);
    chk(d, e);
  endtask
  // ********
  // scenarios
  // ********
  task t_por;
    chk(brg, 1'b1);
    wt(0, 1'b0, POR + 10, 1);
    chk(n >= POR, 1'b1);
    src(32'h01);
    bus(1'b1, 8'h14, 32'hffffffff);
    bus(1'b0, 8'h14, 32'h0);
    chk(d, 32'h0);
    bus(1'b0, CTRL_OFS, 32'h0);
    chk(d, 32'h0);
  endtask
  task t_sw;
    bus(1'b1, SW_HARD_OFS, 32'h1);
    wt(0, 1'b1, 5, 1);
    chk(brg, 1'b0);
    chk(cpu, 1'b1);
    wt(0, 1'b0, SW + 5, 1);
    chk(n, SW);
    src(32'h10);
  endtask
  task t_init;
    bus(1'b1, PROC_INIT_OFS, 32'h1);
    wt(1, 1'b1, 5, 1);
    chk(per, 1'b0);
    wt(1, 1'b0, SOFT_RST_CYC + 5, 1);
    chk(n, SOFT_RST_CYC);
  endtask
  task t_chip;
    bus(1'b1, CHIP_RST_OFS, 32'h1);
    bus(1'b0, CHIP_RST_OFS, 32'h0);
    chk(d, 32'h1);
    chk(brg, 1'b1);
    wt(2, 1'b0, CHIP_RST_CYC + 10, 1);
    bus(1'b0, CHIP_RST_OFS, 32'h0);
    chk(d, 32'h0);
    src(32'h40);
  endtask
  task t_wd;
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, CTRL_OFS, 32'h0);
      wda <= (i == 0);
      wdb <= (i == 1);
      repeat (10) @(posedge clk_i);
      chk(per, 1'b0);
      bus(1'b1, CTRL_OFS, 32'h1 << i);
      bus(1'b0, CTRL_OFS, 32'h0);
      chk(d, 32'h1 << i);
      wt(0, 1'b1, 10, 1);
      wda <= 1'b0;
      wdb <= 1'b0;
      wt(0, 1'b0, POR + 20, 1);
      src(32'h08);
    end
  endtask
  task t_pan;
    press <= 1'b1;
    wt(0, 1'b1, FP - 2, 0);
    chk(n, FP - 2);
    wt(0, 1'b1, 20, 1);
    repeat (20) @(posedge clk_i);
    chk(per, 1'b1);
    press <= 1'b0;
    wt(0, 1'b0, 10, 1);
    src(32'h02);
  endtask
  task t_link;
    bp <= 1'b1;
    wt(0, 1'b1, 8, 1);
    chk(bfr, 1'b0);
    bp <= 1'b0;
    wt(0, 1'b0, 10, 1);
    bus(1'b0, SOURCE_OFS, 32'h0);
    chk(d & 32'h04, 32'h04);
    host <= 1'b1;
    wt(0, 1'b1, 8, 1);
    chk(brg, 1'b0);
    chk(bfr, 1'b1);
    host <= 1'b0;
    wt(0, 1'b0, 10, 1);
    src(32'h20);
  endtask
  task t_pow;
    pg <= 1'b0;
    wt(0, 1'b1, 8, 1);
    pg <= 1'b1;
    wt(0, 1'b0, POR + 10, 1);
    chk(n >= POR, 1'b1);
    src(32'h01);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_por;
    t_sw;
    t_init;
    t_chip;
    t_wd;
    t_pan;
    t_link;
    t_pow;
    test_done;
  end
endmodule
